// File: core/eql_pkg.sv
// Shared constants and types for the low-power-idle and strap register bank
`default_nettype none
package eql_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_PCS_EEE_CONTROL      = 10'h0F2;
    localparam logic [9:0]  IDX_EMPTY_QUEUE_WAIT     = 10'h0F4;
    localparam logic [9:0]  IDX_ALL_PORTS_THRESHOLD  = 10'h0F6;
    localparam logic [9:0]  IDX_STRAP_CONFIGURATION  = 10'h108;
    localparam logic [9:0]  IDX_HOST_ADDRESS_LOW     = 10'h110;
    localparam logic [9:0]  IDX_HOST_ADDRESS_MIDDLE  = 10'h112;
    localparam logic [9:0]  IDX_HOST_ADDRESS_HIGH    = 10'h114;
    localparam int          ADDR_W                   = 12;

    // Reset values and writable masks
    localparam logic [15:0] RST_PCS_EEE_CONTROL      = 16'h0327;
    localparam logic [15:0] WMASK_PCS_EEE_CONTROL    = 16'hC3FF;
    localparam logic [15:0] RST_EMPTY_QUEUE_WAIT     = 16'h03E8;
    localparam logic [7:0]  RST_ALL_PORTS_THRESHOLD  = 8'h40;
    localparam logic [7:0]  RO_ALL_PORTS_UPPER       = 8'hC0;

    // Field positions
    localparam int          POS_NEXT_PAGE_ENABLE     = 8;
    localparam int          POS_BUS_ENDIAN           = 10;
    localparam int          POS_EEPROM_PRESENT       = 9;
    localparam int          POS_BUS_8BIT             = 7;
    localparam int          POS_BUS_16BIT            = 6;
    localparam int          POS_SHARED_BUS           = 4;
    localparam logic [3:0]  STRAP_LOW_NIBBLE         = 4'h2;

    // Threshold unit is 128 bytes
    localparam int          THRESHOLD_SHIFT          = 7;

    // Timing
    localparam int          CLK_PERIOD_NS            = 40;
    localparam int          LPI_UNIT_NS              = 1300000;
    localparam int          LPI_UNIT_CYCLES          = LPI_UNIT_NS / CLK_PERIOD_NS;
    localparam int          EE_HALF_CYCLES           = 8;
    localparam int          STRAP_SETTLE_CYCLES      = 3;

    // Serial EEPROM read command: start bit, opcode, 6-bit word address
    localparam logic [2:0]  EE_READ_OPCODE           = 3'h6;
    localparam logic [1:0]  EE_FIRST_WORD            = 2'h1;
    localparam int          EE_CMD_BITS              = 9;
    localparam int          EE_DATA_SAMPLES          = 17;
    localparam int          EE_WORDS                 = 3;

    localparam logic [1:0]  HRESP_OKAY               = 2'h0;
    localparam int          NUM_PORTS                = 2;

    typedef enum logic [2:0] {
        EE_OFF  = 3'h0,
        EE_CMD  = 3'h1,
        EE_DATA = 3'h3,
        EE_NEXT = 3'h2,
        EE_DONE = 3'h6
    } eql_ee_e;

    // Status of one transmit queue as seen by the idle policy
    typedef struct packed {
        logic        queueEmpty;
        logic        frameEnqueued;
        logic [15:0] bufferBytes;
    } eql_port_s;

    // Serial EEPROM pins driven by the block
    typedef struct packed {
        logic chipSelect;
        logic serialClock;
        logic dataOut;
    } eql_ee_pins_s;

endpackage
`default_nettype wire

// File: core/eql_regs.sv
// Low-power-idle policy, strap capture and host address register bank
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Next-page enable, bit 8, reset 1, gates the next-page exchange.
// - Idle request once a queue stays empty beyond the wait; 1.3 ms units.
// - Wait timer only with 100BASE-TX EEE on; one setting for both ports.
// - Any port above threshold times 128 bytes ends idle on every port.
// - Bus-endian strap is latched into read-only bit 10 at reset.
// - EEPROM-select strap is latched into read-only bit 9 at reset.
// - Bit 7 reads the inverted bus-width strap: 1 means 8-bit bus.
// - Bit 6 reads the bus-width strap directly: 1 means 16-bit bus.
// - Bit 4 always reads 1: address and data share the host bus.
// - With EEPROM fitted, reset loads host address from word 0x1 on.
// - Word 0x1 to low, 0x2 to middle, 0x3 to high register.
// - Software access changes only the registers, never the EEPROM.
module eql_regs #(
    parameter int          LPI_UNIT_CYCLES = eql_pkg::LPI_UNIT_CYCLES,
    parameter int          EE_HALF_CYCLES  = eql_pkg::EE_HALF_CYCLES,
    parameter logic [15:0] HOST_ADDR_RESET = 16'h0000
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    input  wire logic                         hsel,
    input  wire logic [eql_pkg::ADDR_W-1:0]   haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic      [1:0]                   hresp,
    input  wire logic                         busEndianStrap,
    input  wire logic                         eepromSelectStrap,
    input  wire logic                         busWidthStrap,
    input  wire logic                         eepromDataIn,
    output eql_pkg::eql_ee_pins_s             eepromPins,
    input  wire logic                         eee100Enabled,
    input  wire eql_pkg::eql_port_s [1:0]     transmitQueue,
    output logic                              nextPageEnable,
    output logic      [1:0]                   lpiRequest,
    output logic                              lpiExitAll,
    output logic                              hostAddressLoaded
);

    typedef struct packed {
        logic [3:0]       syncA;
        logic [3:0]       syncB;
        logic [1:0]       settle;
        logic             strapsTaken;
        logic             busEndian;
        logic             eepromPresent;
        logic             busWidth;
        logic [15:0]      pcsCtl;
        logic [15:0]      waitVal;
        logic [7:0]       threshold;
        logic [2:0][15:0] hostAddr;
        logic             wrPend;
        logic [9:0]       wrIdx;
        logic [31:0]      rdData;
        logic             readyOut;
        logic [1:0]       resp;
        eql_pkg::eql_ee_e eeState;
        logic [1:0]       eeWord;
        logic [4:0]       bitCnt;
        logic [7:0]       div;
        logic [15:0]      shift;
        eql_pkg::eql_ee_pins_s ee;
        logic             loaded;
        logic [15:0]      pre;
        logic [1:0][15:0] idleCnt;
        logic [1:0]       lpiReq;
        logic             lpiExit;
    } eql_state_s;

    localparam eql_state_s STATE_RESET = '{
        syncA:         4'h0,
        syncB:         4'h0,
        settle:        2'h0,
        strapsTaken:   1'b0,
        busEndian:     1'b0,
        eepromPresent: 1'b0,
        busWidth:      1'b0,
        pcsCtl:        eql_pkg::RST_PCS_EEE_CONTROL,
        waitVal:       eql_pkg::RST_EMPTY_QUEUE_WAIT,
        threshold:     eql_pkg::RST_ALL_PORTS_THRESHOLD,
        hostAddr:      {3{HOST_ADDR_RESET}},
        wrPend:        1'b0,
        wrIdx:         10'h000,
        rdData:        32'h0000_0000,
        readyOut:      1'b1,
        resp:          eql_pkg::HRESP_OKAY,
        eeState:       eql_pkg::EE_OFF,
        eeWord:        2'h0,
        bitCnt:        5'h00,
        div:           8'h00,
        shift:         16'h0000,
        ee:            3'h0,
        loaded:        1'b0,
        pre:           16'h0000,
        idleCnt:       32'h0000_0000,
        lpiReq:        2'h0,
        lpiExit:       1'b0
    };

    localparam logic [7:0]  HALF_LAST = 8'(EE_HALF_CYCLES - 1);
    localparam logic [15:0] PRE_LAST  = 16'(LPI_UNIT_CYCLES - 1);

    eql_state_s cur;
    eql_state_s next_cur;

    // Read command for host address word w (0..2)
    function automatic logic [8:0] eeReadCmd(input logic [1:0] w);
        logic [5:0] addr;
        addr = {4'h0, w + eql_pkg::EE_FIRST_WORD};
        return {eql_pkg::EE_READ_OPCODE, addr};
    endfunction

    // Register read view; unmapped indices read zero
    function automatic logic [15:0] readReg(input eql_state_s s,
                                            input logic [9:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            eql_pkg::IDX_PCS_EEE_CONTROL:     v = s.pcsCtl;
            eql_pkg::IDX_EMPTY_QUEUE_WAIT:    v = s.waitVal;
            eql_pkg::IDX_ALL_PORTS_THRESHOLD:
                v = {eql_pkg::RO_ALL_PORTS_UPPER, s.threshold};
            eql_pkg::IDX_STRAP_CONFIGURATION: begin
                v[3:0] = eql_pkg::STRAP_LOW_NIBBLE;
                v[eql_pkg::POS_SHARED_BUS] = 1'b1;
                v[eql_pkg::POS_BUS_16BIT]  = s.busWidth;
                v[eql_pkg::POS_BUS_8BIT]   = ~s.busWidth;
                v[eql_pkg::POS_EEPROM_PRESENT] = s.eepromPresent;
                v[eql_pkg::POS_BUS_ENDIAN] = s.busEndian;
            end
            eql_pkg::IDX_HOST_ADDRESS_LOW:    v = s.hostAddr[0];
            eql_pkg::IDX_HOST_ADDRESS_MIDDLE: v = s.hostAddr[1];
            eql_pkg::IDX_HOST_ADDRESS_HIGH:   v = s.hostAddr[2];
            default:                          v = 16'h0000;
        endcase
        return v;
    endfunction

    always_comb begin
        logic [8:0]  cmd;
        logic        addrPhase;
        logic        tick;
        logic        overAny;
        logic [15:0] wd;
        cmd       = eeReadCmd(cur.eeWord);
        addrPhase = hsel && htrans[1] && hready;
        tick      = (cur.pre == PRE_LAST);
        overAny   = 1'b0;
        wd        = hwdata[15:0];
        next_cur  = cur;

        // Pin synchronisers; only syncB is read by logic
        next_cur.syncA = {eepromDataIn, busWidthStrap,
                          eepromSelectStrap, busEndianStrap};
        next_cur.syncB = cur.syncA;

        // Straps are taken once the synchronisers hold post-reset values
        if (!cur.strapsTaken) begin
            if (cur.settle == 2'(eql_pkg::STRAP_SETTLE_CYCLES)) begin
                next_cur.strapsTaken   = 1'b1;
                next_cur.busEndian     = cur.syncB[0];
                next_cur.eepromPresent = cur.syncB[1];
                next_cur.busWidth      = cur.syncB[2];
            end else begin
                next_cur.settle = cur.settle + 2'h1;
            end
        end

        // Data phase of a write taken in the previous cycle
        if (cur.wrPend) begin
            next_cur.wrPend = 1'b0;
            unique case (cur.wrIdx)
                eql_pkg::IDX_PCS_EEE_CONTROL:
                    next_cur.pcsCtl = (cur.pcsCtl
                        & ~eql_pkg::WMASK_PCS_EEE_CONTROL)
                        | (wd & eql_pkg::WMASK_PCS_EEE_CONTROL);
                eql_pkg::IDX_EMPTY_QUEUE_WAIT:    next_cur.waitVal = wd;
                eql_pkg::IDX_ALL_PORTS_THRESHOLD:
                    next_cur.threshold = wd[7:0];
                // Register contents only; nothing goes back to the EEPROM
                eql_pkg::IDX_HOST_ADDRESS_LOW:
                    next_cur.hostAddr[0] = wd;
                eql_pkg::IDX_HOST_ADDRESS_MIDDLE:
                    next_cur.hostAddr[1] = wd;
                eql_pkg::IDX_HOST_ADDRESS_HIGH:
                    next_cur.hostAddr[2] = wd;
                default: ;
            endcase
        end

        // Address phase; read data is taken from the post-write view so a
        // read right behind a write sees the new value
        if (addrPhase) begin
            if (hwrite) begin
                next_cur.wrPend = 1'b1;
                next_cur.wrIdx  = haddr[eql_pkg::ADDR_W-1:2];
            end else begin
                next_cur.rdData = {16'h0000,
                    readReg(next_cur, haddr[eql_pkg::ADDR_W-1:2])};
            end
        end
        next_cur.readyOut = 1'b1;
        next_cur.resp     = eql_pkg::HRESP_OKAY;

        // Host address load from the serial EEPROM after reset
        unique case (cur.eeState)
            eql_pkg::EE_OFF: begin
                if (cur.strapsTaken && cur.eepromPresent) begin
                    next_cur.eeState  = eql_pkg::EE_CMD;
                    next_cur.eeWord   = 2'h0;
                    next_cur.bitCnt   = 5'h00;
                    next_cur.div      = HALF_LAST;
                    next_cur.ee       = '{chipSelect: 1'b1,
                                          serialClock: 1'b0,
                                          dataOut: 1'b1};
                end else if (cur.strapsTaken) begin
                    // No EEPROM: software owns the address registers
                    next_cur.eeState = eql_pkg::EE_DONE;
                end
            end
            eql_pkg::EE_CMD, eql_pkg::EE_DATA: begin
                if (cur.div != 8'h00) begin
                    next_cur.div = cur.div - 8'h01;
                end else begin
                    next_cur.div = HALF_LAST;
                    if (!cur.ee.serialClock) begin
                        next_cur.ee.serialClock = 1'b1;
                        // Bit driven after the previous falling edge
                        if (cur.eeState == eql_pkg::EE_DATA) begin
                            next_cur.shift = {cur.shift[14:0], cur.syncB[3]};
                        end
                    end else begin
                        next_cur.ee.serialClock = 1'b0;
                        if (cur.eeState == eql_pkg::EE_CMD) begin
                            if (cur.bitCnt ==
                                5'(eql_pkg::EE_CMD_BITS - 1)) begin
                                next_cur.eeState    = eql_pkg::EE_DATA;
                                next_cur.bitCnt     = 5'h00;
                                next_cur.ee.dataOut = 1'b0;
                            end else begin
                                next_cur.bitCnt     = cur.bitCnt + 5'h01;
                                next_cur.ee.dataOut =
                                    cmd[4'(7) - cur.bitCnt[3:0]];
                            end
                        end else if (cur.bitCnt ==
                                     5'(eql_pkg::EE_DATA_SAMPLES - 1)) begin
                            // Word 1/2/3 to low/middle/high
                            next_cur.hostAddr[cur.eeWord] = cur.shift;
                            next_cur.eeState       = eql_pkg::EE_NEXT;
                            next_cur.ee.chipSelect = 1'b0;
                        end else begin
                            next_cur.bitCnt = cur.bitCnt + 5'h01;
                        end
                    end
                end
            end
            eql_pkg::EE_NEXT: begin
                // Chip select stays low one half period between words
                if (cur.div != 8'h00) begin
                    next_cur.div = cur.div - 8'h01;
                end else if (cur.eeWord == 2'(eql_pkg::EE_WORDS - 1)) begin
                    next_cur.eeState = eql_pkg::EE_DONE;
                    next_cur.loaded  = 1'b1;
                end else begin
                    next_cur.eeWord  = cur.eeWord + 2'h1;
                    next_cur.eeState = eql_pkg::EE_CMD;
                    next_cur.bitCnt  = 5'h00;
                    next_cur.div     = HALF_LAST;
                    next_cur.ee      = '{chipSelect: 1'b1,
                                         serialClock: 1'b0,
                                         dataOut: 1'b1};
                end
            end
            eql_pkg::EE_DONE: begin
                next_cur.ee = 3'h0;
            end
            default: next_cur.eeState = eql_pkg::EE_DONE;
        endcase

        // Shared time base for the empty-queue wait
        next_cur.pre = tick ? 16'h0000 : cur.pre + 16'h0001;

        // Any single port above threshold ends idle everywhere
        for (int p = 0; p < eql_pkg::NUM_PORTS; p++) begin
            if ({8'h00, transmitQueue[p].bufferBytes} >
                ({16'h0000, cur.threshold} << eql_pkg::THRESHOLD_SHIFT)) begin
                overAny = 1'b1;
            end
        end
        next_cur.lpiExit = overAny;

        // One wait setting serves both the network and host queues
        for (int p = 0; p < eql_pkg::NUM_PORTS; p++) begin
            if (!eee100Enabled) begin
                next_cur.idleCnt[p] = 16'h0000;
                next_cur.lpiReq[p]  = 1'b0;
            end else if (!transmitQueue[p].queueEmpty
                         || transmitQueue[p].frameEnqueued) begin
                next_cur.idleCnt[p] = 16'h0000;
                next_cur.lpiReq[p]  = 1'b0;
            end else begin
                // Saturates so a long idle never wraps back to zero
                if (tick && cur.idleCnt[p] != 16'hFFFF) begin
                    next_cur.idleCnt[p] = cur.idleCnt[p] + 16'h0001;
                end
                next_cur.lpiReq[p] = (cur.idleCnt[p] > cur.waitVal)
                                     && !overAny;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= STATE_RESET;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign hrdata            = cur.rdData;
    assign hreadyout         = cur.readyOut;
    assign hresp             = cur.resp;
    assign eepromPins        = cur.ee;
    assign nextPageEnable    =
        cur.pcsCtl[eql_pkg::POS_NEXT_PAGE_ENABLE];
    assign lpiRequest        = cur.lpiReq;
    assign lpiExitAll        = cur.lpiExit;
    assign hostAddressLoaded = cur.loaded;

endmodule

`default_nettype wire

// File: testbench/eql_regs_props.sv
// Checker for bus writes, idle policy and EEPROM load of the register bank
`timescale 1ns/1ns
`default_nettype none
module eql_regs_props #(
    parameter int EE_HALF_CYCLES = eql_pkg::EE_HALF_CYCLES
) (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     ce,
    input wire logic                     hsel,
    input wire logic [11:0]              haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [31:0]              hwdata,
    input wire logic                     hready,
    input wire eql_pkg::eql_ee_pins_s    eepromPins,
    input wire logic                     eee100Enabled,
    input wire eql_pkg::eql_port_s [1:0] transmitQueue,
    input wire logic                     nextPageEnable,
    input wire logic [1:0]               lpiRequest,
    input wire logic                     lpiExitAll,
    input wire logic                     hostAddressLoaded
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Data phase of a control register write; skRun is the clock phase length
    logic pcsWr;
    int   skRun;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcsWr <= 1'b0;
            skRun <= 0;
        end else begin
            if (ce && hready)
                pcsWr <= hsel && htrans[1] && hwrite
                    && haddr == {eql_pkg::IDX_PCS_EEE_CONTROL, 2'h0};
            skRun <= $changed(eepromPins.serialClock) ? 1 : skRun + 1;
        end
    end
    a_npe_reset: assert property (
        $fell(rst) |-> nextPageEnable && lpiRequest == 2'h0)
        else $error("next-page enable or idle request wrong after reset");
    a_npe_write: assert property (
        pcsWr && ce |=> nextPageEnable == $past(hwdata[8]))
        else $error("next-page enable does not follow the written bit");
    a_lpi_eee: assert property (
        !eee100Enabled |=> lpiRequest == 2'h0)
        else $error("idle request while EEE is off");
    a_lpi_restart: assert property (
        !transmitQueue[0].queueEmpty || transmitQueue[0].frameEnqueued
        |=> !lpiRequest[0])
        else $error("idle request kept after queue activity");
    a_exit_hold: assert property (
        lpiExitAll [*2] |-> lpiRequest == 2'h0)
        else $error("idle request while load exit is active");
    a_exit_idle: assert property (
        transmitQueue[0].bufferBytes == 16'h0000
        && transmitQueue[1].bufferBytes == 16'h0000 |=> !lpiExitAll)
        else $error("load exit with empty buffers");
    a_ee_half: assert property (
        $changed(eepromPins.serialClock) |-> skRun >= EE_HALF_CYCLES)
        else $error("EEPROM clock phase too short");
    a_load_quiet: assert property (
        hostAddressLoaded |-> !eepromPins.chipSelect [*3])
        else $error("EEPROM selected after the address load");
    c_idle: cover property ($rose(lpiRequest[0]));
    c_exit: cover property ($rose(lpiExitAll));
    c_load: cover property ($rose(hostAddressLoaded));
endmodule
bind eql_regs eql_regs_props #(.EE_HALF_CYCLES(EE_HALF_CYCLES)) props_u (
    .clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .eepromPins, .eee100Enabled, .transmitQueue, .nextPageEnable,
    .lpiRequest, .lpiExitAll, .hostAddressLoaded
);
`default_nettype wire

// File: testbench/eql_eeprom_model.sv
// Serial EEPROM model answering read commands with a stored host address
`timescale 1ns/1ns
`default_nettype none
module eql_eeprom_model (
    input  wire logic                  clk,
    input  wire eql_pkg::eql_ee_pins_s pins,
    output logic                       dataOut,
    output int                         badCmd
);
    logic        skLast = 1'b0;
    logic [8:0]  cmd = 9'h000;
    logic [15:0] curWord = 16'h0000;
    int          edges = 0;

    function automatic logic [15:0] word(input logic [5:0] a);
        case (a)
            6'h01: return 16'h89AB;
            6'h02: return 16'h4567;
            6'h03: return 16'h0123;
            default: return 16'hFFFF;
        endcase
    endfunction

    initial dataOut = 1'b0;
    initial badCmd = 0;
    always @(posedge clk) begin
        skLast <= pins.serialClock;
        if (!pins.chipSelect) begin
            edges <= 0;
            // No pull on a released line, so keep it moving
            dataOut <= ~dataOut;
        end else if (pins.serialClock && !skLast) begin
            cmd <= {cmd[7:0], pins.dataOut};
            // Anything but a read could alter the stored words
            if (edges == 2 && {cmd[1:0], pins.dataOut} != 3'h6)
                badCmd <= badCmd + 1;
            edges <= edges + 1;
        end else if (!pins.serialClock && skLast) begin
            if (edges == 9) begin
                curWord <= word(cmd[5:0]);
                dataOut <= 1'b0;
            end else if (edges >= 10 && edges <= 25)
                dataOut <= curWord[25 - edges];
        end
    end
endmodule
`default_nettype wire

// File: testbench/eql_regs_bench.sv
// Self-checking bench for the low-power-idle and strap register bank
`timescale 1ns/1ns
`default_nettype none
module eql_regs_bench;
    typedef struct {
        logic [11:0] a;
        logic        w;
        logic [31:0] d;
        logic [15:0] e;
    } eql_row_s;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]               htrans = 2'h0;
    logic [11:0]              haddr = 12'h000;
    logic [31:0]              hwdata = 32'h0;
    logic                     busEndianStrap = 1'b1, eepromSelectStrap = 1'b1;
    logic                     busWidthStrap = 1'b0;
    logic                     eee100Enabled = 1'b0;
    eql_pkg::eql_port_s [1:0] transmitQueue = '0;
    logic [31:0]              hrdata, r;
    logic [1:0]               hresp, lpiRequest;
    logic                     hreadyout, nextPageEnable, lpiExitAll;
    logic                     hostAddressLoaded, eepromDataIn;
    eql_pkg::eql_ee_pins_s    eepromPins;
    int                       badCmd, n, err_total = 0, num_checks = 0;
    eql_row_s rows [13] = '{
        '{12'h3C8, 1'b0, 32'h0, 16'h0327}, '{12'h3D0, 1'b0, 32'h0, 16'h03E8},
        '{12'h3D8, 1'b0, 32'h0, 16'hC040}, '{12'h420, 1'b1, 32'h0, 16'h0692},
        '{12'h440, 1'b0, 32'h0, 16'h89AB}, '{12'h448, 1'b0, 32'h0, 16'h4567},
        '{12'h450, 1'b0, 32'h0, 16'h0123},
        '{12'h3C8, 1'b1, 32'hFFFF_FFFF, 16'hC3FF},
        '{12'h3D8, 1'b1, 32'h0000_FF01, 16'hC001},
        '{12'h3E0, 1'b1, 32'h0000_FFFF, 16'h0000},
        '{12'h440, 1'b1, 32'hABCD_1234, 16'h1234},
        '{12'h3D0, 1'b1, 32'hFFFF_0002, 16'h0002},
        '{12'h3C8, 1'b1, 32'h0000_0027, 16'h0027}};

    eql_regs #(.LPI_UNIT_CYCLES(4), .EE_HALF_CYCLES(4)) dut_u (
        .clk, .rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .busEndianStrap, .eepromSelectStrap, .busWidthStrap, .eepromDataIn,
        .eepromPins, .eee100Enabled, .transmitQueue, .nextPageEnable,
        .lpiRequest, .lpiExitAll, .hostAddressLoaded);
    eql_eeprom_model ee_u (.clk, .pins(eepromPins), .dataOut(eepromDataIn),
        .badCmd);

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chkReg(input logic [31:0] g, e, input string m);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic chkBit(input logic g, e, input string m);
        chkReg({31'h0, g}, {31'h0, e}, m);
    endtask
    // Entered just after a rising edge; returns at the data phase edge
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chkReg({30'h0, hresp}, 32'h0, "response");
    endtask

    always #20 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        $display("mismatch at %0t: watchdog expired", $time);
        err_total++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (n = 0; n < 3000 && hostAddressLoaded !== 1'b1; n++)
            @(negedge clk);
        chkBit(hostAddressLoaded, 1'b1, "address load");
        @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].w)
                bus(rows[i].a, 1'b1, rows[i].d, r);
            bus(rows[i].a, 1'b0, 32'h0, r);
            chkReg(r, {16'h0, rows[i].e}, "row");
        end
        chkReg(badCmd, 32'h0, "eeprom command");
        chkBit(nextPageEnable, 1'b0, "next page");
        $display("test registers done");
        transmitQueue[0].queueEmpty <= 1'b1;
        repeat (30) @(negedge clk);
        chkReg(lpiRequest, 32'h0, "eee off");
        @(posedge clk);
        eee100Enabled <= 1'b1;
        for (n = 0; n < 100 && lpiRequest[0] !== 1'b1; n++)
            @(negedge clk);
        chkBit(n >= 9 && n <= 20 && !lpiRequest[1], 1'b1, "wait");
        @(posedge clk);
        transmitQueue[0].frameEnqueued <= 1'b1;
        @(posedge clk);
        transmitQueue[0].frameEnqueued <= 1'b0;
        @(negedge clk);
        chkBit(lpiRequest[0], 1'b0, "frame restarts wait");
        @(posedge clk);
        transmitQueue[1].queueEmpty <= 1'b1;
        for (n = 0; n < 100 && lpiRequest !== 2'h3; n++)
            @(negedge clk);
        chkReg(lpiRequest, 32'h3, "both ports idle");
        @(posedge clk);
        transmitQueue[1].bufferBytes <= 16'h0080;
        repeat (4) @(negedge clk);
        chkBit(lpiExitAll, 1'b0, "load at threshold");
        @(posedge clk);
        transmitQueue[1].bufferBytes <= 16'h0081;
        repeat (3) @(negedge clk);
        chkReg({lpiExitAll, lpiRequest}, 32'h4, "load over threshold");
        @(posedge clk);
        transmitQueue[1].bufferBytes <= 16'h0000;
        eee100Enabled <= 1'b0;
        repeat (3) @(negedge clk);
        chkReg({lpiExitAll, lpiRequest}, 32'h0, "eee off again");
        $display("test idle policy done");
        @(posedge clk);
        rst <= 1'b1;
        eepromSelectStrap <= 1'b0;
        busEndianStrap <= 1'b0;
        busWidthStrap <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (800) @(posedge clk);
        bus(12'h420, 1'b0, 32'h0, r);
        chkReg(r, 32'h0052, "straps");
        chkBit(hostAddressLoaded, 1'b0, "no load without eeprom");
        bus(12'h440, 1'b0, 32'h0, r);
        chkReg(r, 32'h0, "address after reset");
        bus(12'h440, 1'b1, 32'h0000_5555, r);
        bus(12'h440, 1'b0, 32'h0, r);
        chkReg(r, 32'h5555, "address set by host");
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
